/* File: dbm_match_bank.sv */
// dbm_match_bank: register bank and match logic for the data breakpoints
// assumes an avalon-mm master on the processor clock and a load/store bus
// presented one transaction per cycle with busValid
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dbm_params.svh"

module dbm_match_bank
   import dbm_pkg::*;
#(
   parameter bit TLB_MMU = 1'b1,
   parameter int DATA_BYTES = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [`DBM_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // observed load/store bus
   input wire logic busValid,
   input wire logic busStore,
   input wire logic busDouble,
   input wire logic [31:0] busAddr,
   input wire logic [7:0] busAsid,
   input wire logic [DATA_BYTES-1:0] busByteEn,
   input wire logic [63:0] busData,
   // debug events
   output logic [`DBM_NUM_BP-1:0] breakReq,
   output logic [`DBM_NUM_BP-1:0] triggerReq,
   output logic irq
);

   dbm_regs_t state_q;
   dbm_regs_t state_d;
   logic [`DBM_NUM_BP-1:0] condMet;

   // fixed mapping: no tlb, asid register reserved
   localparam bit FIXED_MAPPING = !TLB_MMU;

   // returns 1 and the breakpoint number when the address falls in a breakpoint page
   function automatic logic bpHit(input logic [`DBM_ADDR_W-1:0] a, output int idx);
      logic [5:0] page;
      page = a[`DBM_ADDR_W-1:8];
      idx = 0;
      bpHit = 1'b0;
      for (int n = 0; n < `DBM_NUM_BP; n++) begin
         if (page == `DBM_OFS_BP_PAGE0 + 6'(n)) begin
            idx = n;
            bpHit = 1'b1;
         end
      end
   endfunction

   function automatic logic [31:0] readWord(input dbm_regs_t s,
                                            input logic [`DBM_ADDR_W-1:0] a);
      int n;
      logic hit;
      logic [31:0] w;
      w = 32'h00000000;
      hit = bpHit(a, n);
      if (a == `DBM_OFS_STATUS) begin
         w[`DBM_STAT_ASID_SUP] = TLB_MMU;
         w[`DBM_STAT_COUNT_LSB +: 4] = 4'(`DBM_NUM_BP);
         w[`DBM_NUM_BP-1:0] = s.matchStatus;
      end else if (a == `DBM_OFS_IRQ_MASK) begin
         w[`DBM_NUM_BP-1:0] = s.irqMask;
      end else if (hit) begin
         case (a[7:0])
            `DBM_OFS_ADDR: w = s.bpAddr[n];
            `DBM_OFS_AMASK: w = s.bpAddrMask[n];
            `DBM_OFS_ASID: begin
               // upper bits always zero, whole word zero without tlb
               w = FIXED_MAPPING ? 32'h00000000 : {24'h000000, s.bpAsid[n]};
            end
            `DBM_OFS_CTRL: w = s.bpCtrl[n] & `DBM_CTRL_WMASK;
            `DBM_OFS_VAL: w = s.bpValue[n];
            `DBM_OFS_VALH: w = s.bpValueHigh[n];
            default: w = 32'h00000000;
         endcase
      end
      return w;
   endfunction

   for (genvar g = 0; g < `DBM_NUM_BP; g++) begin : gBp
      dbm_bp_compare #(
         .DATA_BYTES(DATA_BYTES)
      ) uCmp (
         .cfgAddr(state_q.bpAddr[g]),
         .cfgAddrMask(state_q.bpAddrMask[g]),
         .cfgAsid(state_q.bpAsid[g]),
         .cfgCtrl(state_q.bpCtrl[g]),
         .cfgValue({state_q.bpValueHigh[g], state_q.bpValue[g]}),
         .asidSupported(TLB_MMU),
         .busValid(busValid),
         .busStore(busStore),
         .busDouble(busDouble),
         .busAddr(busAddr),
         .busAsid(busAsid),
         .busByteEn(busByteEn),
         .busData(busData),
         .condMet(condMet[g])
      );
   end

   always_comb begin
      int n;
      logic hit;
      logic doWrite;
      logic [`DBM_NUM_BP-1:0] enabled;
      logic [`DBM_NUM_BP-1:0] clearBits;
      n = 0;
      hit = 1'b0;
      doWrite = 1'b0;
      enabled = '0;
      clearBits = '0;
      state_d = state_q;

      // one wait cycle per access; ack drops after the accepting edge
      state_d.ack = (read || write) && !state_q.ack;
      if ((read || write) && !state_q.ack) begin
         state_d.readData = read ? readWord(state_q, address) : 32'h00000000;
      end
      doWrite = write && state_q.ack;

      hit = bpHit(address, n);
      if (doWrite && hit) begin
         case (address[7:0])
            `DBM_OFS_ADDR: state_d.bpAddr[n] = writedata;
            `DBM_OFS_AMASK: state_d.bpAddrMask[n] = writedata;
            `DBM_OFS_ASID: state_d.bpAsid[n] = writedata[7:0];
            `DBM_OFS_CTRL: state_d.bpCtrl[n] = writedata & `DBM_CTRL_WMASK;
            `DBM_OFS_VAL: state_d.bpValue[n] = writedata;
            `DBM_OFS_VALH: state_d.bpValueHigh[n] = writedata;
            default: state_d.bpAddr[n] = state_q.bpAddr[n];
         endcase
      end
      if (doWrite && address == `DBM_OFS_IRQ_MASK) begin
         state_d.irqMask = writedata[`DBM_NUM_BP-1:0];
      end
      if (doWrite && address == `DBM_OFS_STATUS) begin
         clearBits = writedata[`DBM_NUM_BP-1:0];
      end

      for (int i = 0; i < `DBM_NUM_BP; i++) begin
         enabled[i] = state_q.bpCtrl[i][`DBM_CTRL_BREAK_EN] ||
                      state_q.bpCtrl[i][`DBM_CTRL_TRIG_EN];
      end
      // a match in the clearing cycle survives the clear
      state_d.matchStatus = (state_q.matchStatus & ~clearBits) |
                            (condMet & enabled);

      for (int i = 0; i < `DBM_NUM_BP; i++) begin
         state_d.breakReq[i] = condMet[i] && state_q.bpCtrl[i][`DBM_CTRL_BREAK_EN];
         state_d.triggerReq[i] = condMet[i] && state_q.bpCtrl[i][`DBM_CTRL_TRIG_EN];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         // only the enables must reset; the rest is zeroed for determinism
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign waitrequest = (read || write) && !state_q.ack;
   assign readdata = state_q.readData;
   assign breakReq = state_q.breakReq;
   assign triggerReq = state_q.triggerReq;
   assign irq = |(state_q.matchStatus & state_q.irqMask);

endmodule // dbm_match_bank

/* File: dbm_params.svh */
// dbm_params.svh: offsets, field positions and reset values for the data breakpoint bank
// assumes byte addressing over a 32-bit avalon-mm port, two breakpoints
`ifndef DBM_PARAMS_SVH
`define DBM_PARAMS_SVH

`define DBM_NUM_BP 2
`define DBM_ADDR_W 14

`define DBM_OFS_STATUS 14'h2000
`define DBM_OFS_IRQ_MASK 14'h2004
`define DBM_OFS_BP_PAGE0 6'h21
`define DBM_OFS_ADDR 8'h00
`define DBM_OFS_AMASK 8'h08
`define DBM_OFS_ASID 8'h10
`define DBM_OFS_CTRL 8'h18
`define DBM_OFS_VAL 8'h20
`define DBM_OFS_VALH 8'h24

`define DBM_CTRL_ASID_USE 23
`define DBM_CTRL_BAI_LSB 14
`define DBM_CTRL_NO_STORE 13
`define DBM_CTRL_NO_LOAD 12
`define DBM_CTRL_BLM_LSB 4
`define DBM_CTRL_TRIG_EN 2
`define DBM_CTRL_BREAK_EN 0
`define DBM_CTRL_WMASK 32'h00bffff5
`define DBM_ASID_WMASK 32'h000000ff

`define DBM_STAT_ASID_SUP 30
`define DBM_STAT_COUNT_LSB 24

`define DBM_RESET_WORD 32'h00000000

`endif

/* File: dbm_pkg.sv */
// dbm_pkg: state types of the data breakpoint bank
// assumes dbm_params.svh is on the include path
`include "dbm_params.svh"

package dbm_pkg;

   typedef struct packed {
      logic [`DBM_NUM_BP-1:0][31:0] bpAddr;
      logic [`DBM_NUM_BP-1:0][31:0] bpAddrMask;
      logic [`DBM_NUM_BP-1:0][7:0] bpAsid;
      logic [`DBM_NUM_BP-1:0][31:0] bpCtrl;
      logic [`DBM_NUM_BP-1:0][31:0] bpValue;
      logic [`DBM_NUM_BP-1:0][31:0] bpValueHigh;
      logic [`DBM_NUM_BP-1:0] matchStatus;
      logic [`DBM_NUM_BP-1:0] irqMask;
      logic ack;
      logic [31:0] readData;
      logic [`DBM_NUM_BP-1:0] breakReq;
      logic [`DBM_NUM_BP-1:0] triggerReq;
   } dbm_regs_t;

endpackage

/* File: dbm_bp_compare.sv */
// dbm_bp_compare: match condition of one data breakpoint
// assumes a 64-bit data bus with byte enables, sampled in the same cycle
`timescale 1ns/1ps
`include "dbm_params.svh"

module dbm_bp_compare
   import dbm_pkg::*;
#(
   parameter int DATA_BYTES = 8
) (
   // configuration
   input wire logic [31:0] cfgAddr,
   input wire logic [31:0] cfgAddrMask,
   input wire logic [7:0] cfgAsid,
   input wire logic [31:0] cfgCtrl,
   input wire logic [63:0] cfgValue,
   input wire logic asidSupported,
   // observed transaction
   input wire logic busValid,
   input wire logic busStore,
   input wire logic busDouble,
   input wire logic [31:0] busAddr,
   input wire logic [7:0] busAsid,
   input wire logic [DATA_BYTES-1:0] busByteEn,
   input wire logic [63:0] busData,
   // result
   output logic condMet
);

   function automatic logic [63:0] laneExpand(input logic [DATA_BYTES-1:0] lanes);
      logic [63:0] m;
      m = '0;
      for (int i = 0; i < DATA_BYTES; i++) begin
         m[i*8 +: 8] = {8{lanes[i]}};
      end
      return m;
   endfunction

   logic addrHit;
   logic asidHit;
   logic typeOk;
   logic byteHit;
   logic valueHit;
   logic [DATA_BYTES-1:0] cmpLanes;

   always_comb begin
      addrHit = ((busAddr ^ cfgAddr) & ~cfgAddrMask) == 32'h00000000;
      // asid compare only when supported and enabled
      asidHit = !(asidSupported && cfgCtrl[`DBM_CTRL_ASID_USE]) ||
                (busAsid == cfgAsid);
      typeOk = busStore ? !cfgCtrl[`DBM_CTRL_NO_STORE]
                        : !cfgCtrl[`DBM_CTRL_NO_LOAD];
      // at least one accessed byte must not be ignored
      byteHit = (busByteEn & ~cfgCtrl[`DBM_CTRL_BAI_LSB +: DATA_BYTES]) != '0;
      // upper word only compared on double-word transfers
      cmpLanes = busByteEn & ~cfgCtrl[`DBM_CTRL_BLM_LSB +: DATA_BYTES];
      if (!busDouble) begin
         cmpLanes[DATA_BYTES-1:4] = '0;
      end
      valueHit = ((busData ^ cfgValue) & laneExpand(cmpLanes)) == 64'h0000000000000000;
      condMet = busValid && addrHit && asidHit && typeOk && byteHit && valueHit;
   end

endmodule // dbm_bp_compare

/* File: dbm_match_props.sv */
// dbm_match_props: port assertions for the data breakpoint bank
// assumes one wait cycle per access and events one edge after busValid
`timescale 1ns/1ps

module dbm_match_props
   import dbm_pkg::*;
#(
   parameter bit TLB_MMU = 1'b1
) (
   // clock and register bus
   input wire logic clock,
   input wire logic srst,
   input wire logic [13:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // load/store bus and events
   input wire logic busValid,
   input wire logic [7:0] busByteEn,
   input wire logic [1:0] breakReq,
   input wire logic [1:0] triggerReq,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   sequence reqStart; $rose(read | write); endsequence
   sequence readDone; read && !waitrequest && address[13:10] == 4'h8; endsequence
   sequence wrDone; $past(write && !waitrequest); endsequence
   // a match needs a real transaction with some byte accessed
   sequence busSeen; $past(busValid) && $past(busByteEn) != 8'h00; endsequence

   wait_first_a: assert property (reqStart |-> waitrequest) else $error("no wait cycle");
   one_wait_a: assert property ((read | write) && waitrequest |=> !waitrequest)
      else $error("second wait cycle");
   break_cause_a: assert property (breakReq != 2'b00 |-> busSeen)
      else $error("break without transaction");
   trig_cause_a: assert property (triggerReq != 2'b00 |-> busSeen)
      else $error("trigger without transaction");
   ctrl_res_a: assert property (readDone ##0 address[7:0] == 8'h18 |->
      (readdata & 32'hff40000a) == 32'h0) else $error("control reserved bits set");
   asid_res_a: assert property (readDone ##0 address[7:0] == 8'h10 |->
      readdata[31:8] == 24'h0 && (TLB_MMU || readdata == 32'h0)) else $error("asid bits set");
   irq_rise_a: assert property ($rose(irq) |-> (breakReq | triggerReq) != 2'b00 or wrDone)
      else $error("irq without cause");
   irq_fall_a: assert property ($fell(irq) |-> wrDone) else $error("irq dropped alone");
endmodule // dbm_match_props

bind dbm_match_bank dbm_match_props #(.TLB_MMU(TLB_MMU)) dbm_match_props_i (
   .clock, .srst, .address, .read, .write, .readdata, .waitrequest,
   .busValid, .busByteEn, .breakReq, .triggerReq, .irq
);

/* File: dbm_lsu_model.sv */
// dbm_lsu_model: processor load/store bus seen by the breakpoint bank
// assumes the bench calls issue(); one transaction lasts one clock
`timescale 1ns/1ps

module dbm_lsu_model (
   // clock
   input wire logic clock,
   // load/store bus
   output logic busValid,
   output logic busStore,
   output logic busDouble,
   output logic [31:0] busAddr,
   output logic [7:0] busAsid,
   output logic [7:0] busByteEn,
   output logic [63:0] busData
);
   initial begin
      {busValid, busStore, busDouble, busAddr, busAsid, busByteEn, busData} = '0;
   end
   task automatic issue(input logic st, dbl, input logic [31:0] a, input logic [63:0] d);
      @(posedge clock);
      {busValid, busStore, busDouble, busAddr, busData} <= {1'b1, st, dbl, a, d};
      busByteEn <= dbl ? 8'hff : 8'h0f;
      @(posedge clock);
      // idle bus shows inverted junk so a stale value cannot match by luck
      {busValid, busAddr, busData} <= {1'b0, ~a, ~d};
   endtask
endmodule // dbm_lsu_model

/* File: tb_data_breakpoint_match_control.sv */
// tb_data_breakpoint_match_control: register and match checks of the bank
// assumes dbm_lsu_model drives the load/store bus, checker bound to the bank
`timescale 1ns/1ps

module tb_data_breakpoint_match_control;
   localparam logic [63:0] M = 64'h9abcdef0_12345678;
   localparam logic [63:0] W = 64'h9abcdef0_12345600;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [13:0] address = 14'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, q, busAddr;
   logic [31:0] readdataFm, qFm;
   logic [1:0] breakReqFm;
   logic waitrequest, busValid, busStore, busDouble, irq;
   logic [7:0] busAsid, busByteEn;
   logic [63:0] busData;
   logic [1:0] breakReq, triggerReq;
   int badCount = 0;
   int testsRun = 0;

   dbm_match_bank #(.TLB_MMU(1'b1), .DATA_BYTES(8)) dbm_match_bank_i (
      .clock, .srst, .address, .read, .write, .writedata, .readdata, .waitrequest,
      .busValid, .busStore, .busDouble, .busAddr, .busAsid, .busByteEn, .busData,
      .breakReq, .triggerReq, .irq
   );
   // second bank without asid support, sharing both buses with the first
   dbm_match_bank #(.TLB_MMU(1'b0), .DATA_BYTES(8)) dbm_match_bank_fm_i (
      .clock, .srst, .address, .read, .write, .writedata, .readdata(readdataFm),
      .waitrequest(), .busValid, .busStore, .busDouble, .busAddr, .busAsid, .busByteEn,
      .busData, .breakReq(breakReqFm), .triggerReq(), .irq()
   );
   dbm_lsu_model dbm_lsu_model_i (
      .clock, .busValid, .busStore, .busDouble, .busAddr, .busAsid, .busByteEn, .busData
   );
   initial begin
      forever #5 clock = ~clock;
   end

   task automatic wrapUp();
      $display("checks %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, got);
      testsRun++;
      if (got !== exp) begin
         badCount++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // request stands until a rising edge sees waitrequest low; data taken at that edge
   task automatic acc(input logic w, input logic [13:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      {address, writedata, write, read} <= {a, d, w, ~w};
      for (n = 0; n < 20; n++) begin
         @(posedge clock);
         if (waitrequest === 1'b0) break;
      end
      if (n == 20) begin
         badCount++;
         wrapUp();
      end
      q = readdata;
      qFm = readdataFm;
      {write, read} <= 2'b00;
   endtask
   task automatic run(input logic [31:0] c, a, input logic st, dbl, input logic [63:0] d,
                      input logic [3:0] e);
      acc(1'b1, 14'h2118, c);
      dbm_lsu_model_i.issue(st, dbl, a, d);
      #1 chk("events", {28'h0, e}, {28'h0, triggerReq, breakReq});
   endtask

   initial begin
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      acc(1'b0, 14'h2118, 32'h0);
      chk("ctrl reset", 32'h0, q);
      acc(1'b1, 14'h2118, 32'hffffffff);
      acc(1'b0, 14'h2118, 32'h0);
      chk("ctrl", 32'h00bffff5, q);
      acc(1'b1, 14'h2210, 32'hffffffff);
      acc(1'b0, 14'h2210, 32'h0);
      chk("asid", 32'h000000ff, q);
      chk("asid fm", 32'h0, qFm);
      acc(1'b0, 14'h0004, 32'h0);
      chk("unmapped", 32'h0, q);
      $display("test registers done");
      acc(1'b1, 14'h2100, 32'h00001000);
      acc(1'b1, 14'h2108, 32'h00000010);
      acc(1'b1, 14'h2110, 32'h0000005a);
      acc(1'b1, 14'h2120, 32'h12345678);
      acc(1'b1, 14'h2124, 32'h9abcdef0);
      run(32'h1, 32'h1000, 1'b0, 1'b0, M, 4'h1);
      run(32'h4, 32'h1000, 1'b0, 1'b0, M, 4'h4);
      run(32'h1001, 32'h1000, 1'b0, 1'b0, M, 4'h0);
      run(32'h1001, 32'h1000, 1'b1, 1'b0, M, 4'h1);
      run(32'h2001, 32'h1000, 1'b1, 1'b0, M, 4'h0);
      run(32'h1, 32'h1000, 1'b0, 1'b0, W, 4'h0);
      run(32'h11, 32'h1000, 1'b0, 1'b0, W, 4'h1);
      run(32'h3c001, 32'h1000, 1'b0, 1'b0, M, 4'h0);
      run(32'h800001, 32'h1000, 1'b0, 1'b0, M, 4'h0);
      chk("break fm", 32'h1, {30'h0, breakReqFm});
      acc(1'b1, 14'h2110, 32'h00000000);
      run(32'h800001, 32'h1000, 1'b0, 1'b0, M, 4'h1);
      run(32'h1, 32'h1010, 1'b0, 1'b0, M, 4'h1);
      run(32'h1, 32'h1020, 1'b0, 1'b0, M, 4'h0);
      run(32'h1, 32'h1000, 1'b0, 1'b1, M ^ 64'h1 << 40, 4'h0);
      run(32'h1, 32'h1000, 1'b0, 1'b1, M, 4'h1);
      $display("test match done");
      acc(1'b0, 14'h2000, 32'h0);
      chk("status", 32'h42000001, q);
      chk("irq masked", 32'h0, {31'h0, irq});
      acc(1'b1, 14'h2004, 32'h1);
      #1 chk("irq", 32'h1, {31'h0, irq});
      acc(1'b1, 14'h2000, 32'h1);
      #1 chk("irq clear", 32'h0, {31'h0, irq});
      acc(1'b1, 14'h2218, 32'h1);
      dbm_lsu_model_i.issue(1'b0, 1'b0, 32'h0, 64'h0);
      #1 chk("bp1", 32'h2, {30'h0, breakReq});
      acc(1'b0, 14'h2000, 32'h0);
      chk("status bp1", 32'h42000002, q);
      $display("test irq done");
      wrapUp();
   end
endmodule // tb_data_breakpoint_match_control
